/* File: shared/qdr_pkg.sv */
// Shared constants, types and carriers for the burst-of-four memory cycle control
package qdr_pkg;
	localparam int ADDR_W            = 21;
	localparam int DATA_W            = 18;
	localparam int CLOCK_PERIOD_NS   = 10;
	localparam int KSTOP_TIME_NS     = 30;
	localparam int KSTOP_CYCLES      = (KSTOP_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int LOCK_CYCLES       = 2048;
	localparam int BURST_LEN         = 4;
	localparam int LAT_DLL_HALVES    = 5;
	localparam int LAT_BYPASS_HALVES = 2;
	localparam int WR_FIRST_HALF     = 2;
	localparam int PIPE_DEPTH        = 8;
	localparam int FIFO_DEPTH        = 16;
	localparam logic [3:0] IDLE_RESET = 4'h0;
	localparam logic [11:0] LOCK_RESET = 12'h000;

	typedef logic [ADDR_W-1:0] addr_t;
	typedef logic [DATA_W-1:0] data_t;

	typedef enum logic [1:0] {
		DLL_RESET   = 2'b00,
		DLL_LOCKING = 2'b01,
		DLL_READY   = 2'b11,
		DLL_BYPASS  = 2'b10
	} dll_state_e;

	typedef struct packed {
		addr_t addr;
		data_t data;
	} beat_s;

	typedef struct packed {
		logic  k;
		logic  read_sel_n;
		logic  write_sel_n;
		logic  dll_off_n;
		addr_t addr;
		data_t d;
	} pins_s;
endpackage

/* File: design/beat_fifo.sv */
// Valid/ready FIFO with a registered output stage
`timescale 1ns/1ps
`default_nettype none
module beat_fifo #(
	parameter int WIDTH = 39,
	parameter int DEPTH = 16
) (
	input  wire logic             clock,
	input  wire logic             reset_n,
	input  wire logic             in_valid,
	output var  logic             in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output var  logic             out_valid,
	input  wire logic             out_ready,
	output var  logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wptr;
	logic [PW-1:0]    rptr;
	logic [PW:0]      count;
	logic [PW:0]      next_count;
	logic             push;
	logic             load;

	assign push = in_valid && in_ready;
	// Output stage refills whenever it is empty or being taken
	assign load = (count != '0) && (!out_valid || out_ready);
	assign next_count = count + (PW+1)'(push) - (PW+1)'(load);

	always_ff @(posedge clock) begin
		if (push) begin
			mem[wptr] <= in_data;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			wptr     <= '0;
			rptr     <= '0;
			count    <= '0;
			in_ready <= 1'b0;
		end else begin
			if (push) begin
				wptr <= wptr + 1'b1;
			end
			if (load) begin
				rptr <= rptr + 1'b1;
			end
			count    <= next_count;
			// Registered full flag, so the filling side never sees a combinational path.
			// One word sits in the output stage, so the array stops one short of DEPTH
			in_ready <= next_count < (PW+1)'(DEPTH - 1);
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			out_valid <= 1'b0;
			out_data  <= '0;
		end else if (load) begin
			out_valid <= 1'b1;
			out_data  <= mem[rptr];
		end else if (out_ready) begin
			out_valid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* File: design/qdr_burst4_sram_cycle_control.sv */
// Loop lock sequencing, read/write command machines and burst beat timing
`timescale 1ns/1ps
`default_nettype none
// What the document requires
// RULE_01 - Either input clock static for over 30 ns resets the loop for relock.
// RULE_02 - After loop reset, lock over the wait period, then become ready.
// RULE_03 - Rising edge on loop-disable input resets the loop, which then relocks.
// RULE_04 - Controller must reset the loop if disable released before clock stable.
// RULE_05 - Controller must reset the loop after any clock frequency change.
// RULE_06 - Controller must hold all inputs, clocks included, at defined levels at power-on.
// RULE_07 - Burst counter yields start address, then plus one, two and three.
// RULE_08 - Read select low means read active, high means inactive.
// RULE_09 - Write select low means write active, high means inactive.
// RULE_10 - Read and write machines run independently, possibly in the same period.
// RULE_11 - All machine transitions happen on the rising primary clock edge.
// RULE_12 - Read command is sampled on the rising edge starting cycle t.
// RULE_13 - Controller drives write beats at t+2.0, t+2.5, t+3.0, t+3.5 after command; the code takes them at t+1.0, t+1.5, t+2.0, t+2.5.
// RULE_14 - Read beats leave at t+2.5, t+3.0, t+3.5 and t+4.0.
// RULE_15 - No select means no operation and data outputs off; stopped clock holds state.
// RULE_16 - Same-type command on the very next rising edge is ignored.
// RULE_17 - Both selects active right after a no-operation edge: the write is ignored.
// RULE_18 - Loop needs 2048 stable clock cycles after reset to lock.
// RULE_19 - Loop-disable held low bypasses the loop with one-cycle read latency.
module qdr_burst4_sram_cycle_control (
	input  wire logic          clock,
	input  wire logic          reset_n,
	input  wire logic          k_pin,
	input  wire logic          read_sel_n,
	input  wire logic          write_sel_n,
	input  wire logic          dll_off_n,
	input  wire qdr_pkg::addr_t addr_pin,
	input  wire qdr_pkg::data_t d_pin,
	output var  qdr_pkg::data_t q,
	output var  logic          q_oe,
	output var  logic          ready,
	output var  logic          dll_bypass,
	output var  logic          array_rd_req,
	output var  qdr_pkg::addr_t array_rd_addr,
	input  wire qdr_pkg::data_t array_rd_data,
	output var  logic          array_wr_valid,
	input  wire logic          array_wr_ready,
	output var  qdr_pkg::beat_s array_wr,
	output var  logic          write_buffer_ready
);
	import qdr_pkg::*;

	pins_s                  pin_meta;
	pins_s                  pin_sync;
	logic                   k_prev;
	logic                   doff_prev;
	logic                   k_edge;
	logic                   k_rise;
	logic                   k_stopped;
	logic [3:0]             idle_cnt;
	logic [11:0]            lock_cnt;
	dll_state_e             state;
	logic                   op_en;
	logic                   rd_block;
	logic                   wr_block;
	logic                   prev_nop;
	logic                   rd_cmd;
	logic                   wr_cmd;
	logic [PIPE_DEPTH-1:0]  rd_tok;
	logic [PIPE_DEPTH-1:0]  wr_tok;
	addr_t                  rd_apipe [PIPE_DEPTH];
	addr_t                  wr_apipe [PIPE_DEPTH];
	int                     lat;
	logic [2:0]             rd_req_f;
	logic [2:0]             rd_out_f;
	logic [2:0]             wr_f;
	addr_t                  rd_req_addr;
	beat_s                  push_beat;
	logic                   push_valid;
	data_t                  rd_hold;
	logic [1:0]             rd_req_k;
	addr_t                  last_rd_addr;
	logic [3:0]             rd_age;

	// Finds which burst beat, if any, sits in the window starting at stage first
	function automatic logic [2:0] find_beat(input logic [PIPE_DEPTH-1:0] tok, input int first);
		logic [2:0] r;
		r = 3'h0;
		for (int k = 0; k < BURST_LEN; k++) begin
			if (first + k < PIPE_DEPTH && tok[first + k]) begin
				r = {1'b1, 2'(k)};
			end
		end
		return r;
	endfunction

	// Pins come from the far side's timing, so two flops before any logic
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			pin_meta  <= '0;
			pin_sync  <= '0;
			k_prev    <= 1'b0;
			doff_prev <= 1'b0;
		end else begin
			pin_meta  <= '{k: k_pin, read_sel_n: read_sel_n, write_sel_n: write_sel_n,
				dll_off_n: dll_off_n, addr: addr_pin, d: d_pin};
			pin_sync  <= pin_meta;
			k_prev    <= pin_sync.k;
			doff_prev <= pin_sync.dll_off_n;
		end
	end

	assign k_edge    = pin_sync.k != k_prev;
	assign k_rise    = pin_sync.k && !k_prev; // RULE_11
	assign k_stopped = idle_cnt > 4'(KSTOP_CYCLES); // RULE_01

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			idle_cnt <= IDLE_RESET;
		end else if (k_edge) begin
			idle_cnt <= IDLE_RESET;
		end else if (!k_stopped) begin
			idle_cnt <= idle_cnt + 4'h1;
		end
	end

	// Loop sequencing; a disable pin held low overrides everything except reset_n
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			state    <= DLL_RESET;
			lock_cnt <= LOCK_RESET;
		end else if (!pin_sync.dll_off_n) begin
			state <= DLL_BYPASS; // RULE_19
		end else if (k_stopped || !doff_prev) begin
			state    <= DLL_RESET; // RULE_01 RULE_03
			lock_cnt <= LOCK_RESET;
		end else begin
			case (state)
				DLL_RESET: begin
					if (k_rise) begin
						state <= DLL_LOCKING;
					end
				end
				DLL_LOCKING: begin
					if (k_rise) begin
						if (lock_cnt == 12'(LOCK_CYCLES - 1)) begin
							state <= DLL_READY; // RULE_02 RULE_18
						end else begin
							lock_cnt <= lock_cnt + 12'h001;
						end
					end
				end
				DLL_READY: state <= DLL_READY;
				default: state <= DLL_RESET;
			endcase
		end
	end

	assign op_en = (state == DLL_READY) || (state == DLL_BYPASS);

	// Independent machines, both sampled on the rising edge only
	assign rd_cmd = k_rise && op_en && !pin_sync.read_sel_n && !rd_block; // RULE_08 RULE_12 RULE_16
	assign wr_cmd = k_rise && op_en && !pin_sync.write_sel_n && !wr_block // RULE_09 RULE_10
		&& !(prev_nop && !pin_sync.read_sel_n); // RULE_17

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			rd_block <= 1'b0;
			wr_block <= 1'b0;
			prev_nop <= 1'b0;
		end else if (k_rise) begin
			rd_block <= rd_cmd; // RULE_16
			wr_block <= wr_cmd;
			prev_nop <= pin_sync.read_sel_n && pin_sync.write_sel_n;
		end
	end

	// Token pipes advance on every K edge, rising and falling, so a stopped K freezes them
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			rd_tok <= '0;
			wr_tok <= '0;
		end else if (k_edge) begin
			rd_tok <= {rd_tok[PIPE_DEPTH-2:0], rd_cmd}; // RULE_15
			wr_tok <= {wr_tok[PIPE_DEPTH-2:0], wr_cmd};
		end
	end

	always_ff @(posedge clock) begin
		if (k_edge) begin
			rd_apipe[0] <= pin_sync.addr;
			wr_apipe[0] <= pin_sync.addr;
			for (int i = 1; i < PIPE_DEPTH; i++) begin
				rd_apipe[i] <= rd_apipe[i-1];
				wr_apipe[i] <= wr_apipe[i-1];
			end
		end
	end

	always_comb begin
		lat         = (state == DLL_BYPASS) ? LAT_BYPASS_HALVES : LAT_DLL_HALVES; // RULE_19
		rd_req_f    = find_beat(rd_tok, lat - 2);
		rd_out_f    = find_beat(rd_tok, lat - 1); // RULE_14
		wr_f        = find_beat(wr_tok, WR_FIRST_HALF - 1);
		rd_req_addr = rd_apipe[lat - 2 + int'(rd_req_f[1:0])]
			+ ADDR_W'(rd_req_f[1:0]); // RULE_07
		push_beat   = '{addr: wr_apipe[WR_FIRST_HALF - 1 + int'(wr_f[1:0])]
			+ ADDR_W'(wr_f[1:0]), data: pin_sync.d}; // RULE_07
		push_valid  = k_edge && wr_f[2];
	end

	// Array read is fetched one half-cycle ahead so the beat is ready at its edge
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			array_rd_req  <= 1'b0;
			array_rd_addr <= '0;
			rd_req_k      <= 2'h0;
			rd_hold       <= '0;
		end else begin
			array_rd_req <= k_edge && rd_req_f[2];
			if (k_edge && rd_req_f[2]) begin
				array_rd_addr <= rd_req_addr;
				rd_req_k      <= rd_req_f[1:0];
			end
			if (array_rd_req) begin
				rd_hold <= array_rd_data;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			q    <= '0;
			q_oe <= 1'b0;
		end else if (k_edge) begin
			q_oe <= rd_out_f[2]; // RULE_15
			if (rd_out_f[2]) begin
				q <= rd_hold; // RULE_14
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			ready      <= 1'b0;
			dll_bypass <= 1'b0;
		end else begin
			ready      <= op_en; // RULE_02
			dll_bypass <= state == DLL_BYPASS;
		end
	end

	// A full buffer drops beats: the pins cannot be stalled, so the flag is exported
	beat_fifo #(
		.WIDTH ($bits(beat_s)),
		.DEPTH (FIFO_DEPTH)
	) u_write_buffer (
		.clock     (clock),
		.reset_n   (reset_n),
		.in_valid  (push_valid),
		.in_ready  (write_buffer_ready),
		.in_data   (push_beat),
		.out_valid (array_wr_valid),
		.out_ready (array_wr_ready),
		.out_data  (array_wr)
	);

	// Helper state seen only by the checks below
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			last_rd_addr <= '0;
			rd_age       <= 4'hF;
		end else begin
			if (array_rd_req) begin
				last_rd_addr <= array_rd_addr;
			end
			if (rd_cmd) begin
				rd_age <= 4'h0;
			end else if (k_edge && rd_age != 4'hF) begin
				rd_age <= rd_age + 4'h1;
			end
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	a_kstop_reset: assert property ((k_stopped && pin_sync.dll_off_n) |=> state == DLL_RESET) // RULE_01
		else $error("stopped clock did not reset the loop");
	a_lock_wait: assert property ((state == DLL_LOCKING) ##1 (state == DLL_READY) // RULE_18
		|-> $past(lock_cnt) == 12'(LOCK_CYCLES - 1))
		else $error("loop locked before the full wait");
	a_doff_rise: assert property ((pin_sync.dll_off_n && !doff_prev) |=> state == DLL_RESET) // RULE_03
		else $error("disable rising edge did not reset the loop");
	a_bypass_mode: assert property (!pin_sync.dll_off_n |=> state == DLL_BYPASS ##1 dll_bypass) // RULE_19
		else $error("disable low did not bypass the loop");
	a_burst_linear: assert property ((array_rd_req && rd_req_k != 2'h0) // RULE_07
		|-> array_rd_addr == last_rd_addr + ADDR_W'(1))
		else $error("burst address not linear");
	a_read_inactive: assert property ((k_rise && pin_sync.read_sel_n) |=> !rd_tok[0]) // RULE_08
		else $error("read taken with select high");
	a_write_inactive: assert property ((k_rise && pin_sync.write_sel_n) |=> !wr_tok[0]) // RULE_09
		else $error("write taken with select high");
	a_both_active: assert property ((k_rise && op_en && !pin_sync.read_sel_n // RULE_10
		&& !pin_sync.write_sel_n && !rd_block && !wr_block && !prev_nop) |=> rd_tok[0] && wr_tok[0])
		else $error("read and write not taken together");
	a_read_latency: assert property ($rose(q_oe) |-> rd_age == 4'(lat)) // RULE_14
		else $error("first read beat at wrong edge");
	a_same_type_gap: assert property ((k_rise && (rd_tok[1] || wr_tok[1])) // RULE_16
		|-> !(rd_tok[1] && rd_cmd) && !(wr_tok[1] && wr_cmd))
		else $error("back-to-back command accepted");
	a_write_after_nop: assert property ((k_rise && prev_nop && !pin_sync.read_sel_n) |-> !wr_cmd) // RULE_17
		else $error("write not ignored after no-operation");
	a_nop_hiz: assert property ((k_edge && !rd_out_f[2]) |=> !q_oe) // RULE_15
		else $error("data driven outside a read burst");
endmodule
`default_nettype wire

/* File: sim/k_source.sv */
// Host-side source of the primary input clock, with stop support
`timescale 1ns/1ps
`default_nettype none
module k_source (
	input  wire logic       clock,
	input  wire logic       run,
	output var  logic       k_pin,
	output var  logic [2:0] phase,
	output var  int         edges
);
	// K sits at a defined high level from time zero, never floating
	initial begin
		k_pin = 1'b1;
		phase = 3'd2;
		edges = 0;
	end
	// Half period of three clocks; dropping run holds K static, which is how the host
	// forces a relock after an early release or a rate change
	always @(negedge clock) begin
		if (run) begin
			phase <= (phase == 3'd5) ? 3'd0 : phase + 3'd1;
			if (phase == 3'd5 || phase == 3'd2) begin
				k_pin <= (phase == 3'd5);
				edges <= edges + 1;
			end
		end
	end
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench for the burst-of-four cycle control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import qdr_pkg::*;
	typedef struct {int idx; data_t d;} rd_note_s;
	logic       clock = 1'b0;
	logic       reset_n;
	logic       read_sel_n;
	logic       write_sel_n;
	logic       dll_off_n;
	logic       array_wr_ready;
	logic       run;
	logic       hold;
	logic       k_pin;
	logic       q_oe;
	logic       ready;
	logic       dll_bypass;
	logic       array_rd_req;
	logic       array_wr_valid;
	logic       write_buffer_ready;
	addr_t      addr_pin;
	addr_t      array_rd_addr;
	data_t      d_pin;
	data_t      q;
	data_t      array_rd_data;
	beat_s      array_wr;
	logic [2:0] phase;
	int         edges;
	int         es;
	int         rd_lat;
	int         err_total;
	int         checks;
	int         seed = 32'h7F52;
	rd_note_s   rq[$];
	beat_s      wq[$];

	always #5 clock = ~clock;

	function automatic data_t mem(input addr_t a);
		return a[DATA_W-1:0] ^ 18'h15A5A;
	endfunction
	// Array answers in the same clock as the request
	assign array_rd_data = mem(array_rd_addr);

	k_source u_k (.clock(clock), .run(run), .k_pin(k_pin), .phase(phase), .edges(edges));

	qdr_burst4_sram_cycle_control u_dut (
		.clock(clock), .reset_n(reset_n), .k_pin(k_pin), .read_sel_n(read_sel_n),
		.write_sel_n(write_sel_n), .dll_off_n(dll_off_n), .addr_pin(addr_pin), .d_pin(d_pin),
		.q(q), .q_oe(q_oe), .ready(ready), .dll_bypass(dll_bypass),
		.array_rd_req(array_rd_req), .array_rd_addr(array_rd_addr),
		.array_rd_data(array_rd_data), .array_wr_valid(array_wr_valid),
		.array_wr_ready(array_wr_ready), .array_wr(array_wr),
		.write_buffer_ready(write_buffer_ready)
	);

	task automatic check(input logic [38:0] seen, input logic [38:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up;
		$display("checks %0d, mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic wait_ready;
		for (int i = 0; i < 20000 && ready !== 1'b1; i++) @(negedge clock);
		check(39'(ready), 39'd1);
	endtask

	task automatic drain;
		for (int i = 0; i < 400 && wq.size() > 0; i++) @(negedge clock);
	endtask

	// Three command slots on consecutive rising K edges; selects change on falling K so
	// they are steady a half period either side of the rising edge that takes them
	task automatic cmd(input logic [2:0] rd, input logic [2:0] wr, input addr_t a,
			input data_t dat);
		logic [2:0] rt;
		logic [2:0] wt;
		logic       r_prev;
		logic       w_prev;
		logic       nop;
		logic       live;
		int         e0;
		live = (ready === 1'b1);
		r_prev = 1'b0;
		w_prev = 1'b0;
		nop = 1'b1;
		for (int s = 0; s < 3; s++) begin
			rt[s] = live & rd[s] & ~r_prev;
			wt[s] = live & wr[s] & ~w_prev & ~(nop & rd[s]);
			r_prev = rt[s];
			w_prev = wt[s];
			nop = ~rd[s] & ~wr[s];
		end
		do @(negedge clock); while (phase != 3'd2);
		read_sel_n = ~rd[0];
		write_sel_n = ~wr[0];
		addr_pin = a;
		for (int n = 1; n <= 30; n++) begin
			@(negedge clock);
			if (n == 4) begin
				e0 = edges;
				for (int s = 0; s < 3; s++) begin
					for (int b = 0; b < 4; b++) begin
						if (rt[s]) rq.push_back('{e0 + 2*s + rd_lat + b, mem(a + addr_t'(8*s + b))});
						if (wt[s]) wq.push_back('{a + addr_t'(8*s + b), dat + data_t'(2*s + 2 + b)});
					end
				end
			end
			if (n == 6 || n == 12) begin
				read_sel_n = ~rd[n/6];
				write_sel_n = ~wr[n/6];
				addr_pin = a + addr_t'(8*(n/6));
			end
			if (n == 18) begin
				read_sel_n = 1'b1;
				write_sel_n = 1'b1;
			end
			if (n % 3 == 2 && n >= 8) d_pin = dat + data_t'((n - 2) / 3);
		end
	endtask

	always @(negedge clock) array_wr_ready <= hold ? 1'b0 : 1'($random(seed));

	// Beat h is sampled half a clock after the following K edge, a clock after it settled
	always @(posedge clock) begin
		if (reset_n === 1'b1 && (phase == 3'd0 || phase == 3'd3)) begin
			if (rq.size() > 0 && rq[0].idx + 1 == edges) begin
				check(39'(q_oe), 39'd1);
				check(39'(q), 39'(rq[0].d));
				void'(rq.pop_front());
			end else begin
				check(39'(q_oe), 39'd0);
			end
		end
	end

	always @(posedge clock) begin
		if (array_wr_valid === 1'b1 && array_wr_ready) begin
			if (wq.size() == 0) check(39'd1, 39'd0);
			else check(39'(array_wr), 39'(wq.pop_front()));
		end
	end

	initial begin
		#400000;
		err_total++;
		wrap_up();
	end

	initial begin
		reset_n = 1'b0;
		read_sel_n = 1'b1;
		write_sel_n = 1'b1;
		dll_off_n = 1'b0;
		addr_pin = '0;
		d_pin = '0;
		run = 1'b1;
		hold = 1'b0;
		rd_lat = 2;
		repeat (2) @(negedge clock);
		reset_n = 1'b1;
		wait_ready();
		check(39'(dll_bypass), 39'd1);
		cmd(3'b001, 3'b010, 21'h1FFFFE, data_t'($random(seed)));
		cmd(3'b011, 3'b000, 21'h00040, data_t'($random(seed)));
		cmd(3'b000, 3'b011, 21'h00100, data_t'($random(seed)));
		cmd(3'b001, 3'b001, 21'h00200, data_t'($random(seed)));
		// Read and write taken on one edge that follows an ignored read
		cmd(3'b111, 3'b100, 21'h00700, data_t'($random(seed)));
		drain();
		// Array stalls while four bursts fill all sixteen words
		hold = 1'b1;
		for (int i = 0; i < 4; i++) cmd(3'b000, 3'b001, addr_t'(21'h300 + 16*i), data_t'($random(seed)));
		check(39'(write_buffer_ready), 39'd0);
		hold = 1'b0;
		drain();
		es = edges;
		dll_off_n = 1'b1;
		rd_lat = 5;
		repeat (8) @(negedge clock);
		check(39'(ready), 39'd0);
		cmd(3'b001, 3'b001, 21'h00500, data_t'($random(seed)));
		wait_ready();
		check(39'((edges - es) / 2 >= LOCK_CYCLES), 39'd1);
		cmd(3'b001, 3'b010, 21'h00600, data_t'($random(seed)));
		// Pending bursts must finish before K is stopped
		repeat (12) @(negedge clock);
		run = 1'b0;
		repeat (KSTOP_CYCLES + 5) @(negedge clock);
		run = 1'b1;
		repeat (6) @(negedge clock);
		check(39'(ready), 39'd0);
		wait_ready();
		cmd(3'b001, 3'b000, 21'h1FFFFD, data_t'($random(seed)));
		repeat (60) @(negedge clock);
		drain();
		check(39'(rq.size() + wq.size()), 39'd0);
		wrap_up();
	end
endmodule
`default_nettype wire
